// ---- design/bfc_consts.svh ----
// constants for the burst fill cache controller and its processor end
`ifndef BFC_CONSTS_SVH
`define BFC_CONSTS_SVH
`define BFC_ADDR_W       14
`define BFC_DATA_W       32
`define BFC_LANE_W       4
`define BFC_LANES        8
`define BFC_WORDS        4
`define BFC_FIRST_LAT    3
`define BFC_CNT_RST      2'h0
`endif

// ---- design/bfc_pkg.sv ----
// types used by the cache memory end of the burst fill link
package bfc_pkg;
    typedef enum logic [1:0] {
        BFC_IDLE,
        BFC_LEAD,
        BFC_BURST
    } bfc_state_t;
endpackage

// ---- design/bfc_link_if.sv ----
// link between processor end and cache memory end
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.svh"
interface bfc_link_if;
    logic                    burst_request;
    logic                    burst_acknowledge;
    logic                    word_valid;
    logic                    write_enable;
    logic [`BFC_ADDR_W-1:0]  addr;
    logic [`BFC_DATA_W-1:0]  wdata;
    logic [`BFC_DATA_W-1:0]  rdata;
    modport mem (
        input  burst_request,
        input  write_enable,
        input  addr,
        input  wdata,
        output burst_acknowledge,
        output word_valid,
        output rdata
    );
    modport cpu (
        output burst_request,
        output write_enable,
        output addr,
        output wdata,
        input  burst_acknowledge,
        input  word_valid,
        input  rdata
    );
endinterface
`default_nettype wire

// ---- design/bfc_mem_ctrl.sv ----
// cache memory end: burst counter, eight 4-bit synchronous lanes
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.svh"
// Function
// - write captured on edge, no strobe pulse
// - single clock for whole memory subsystem
// - four words delivered 3-1-1-1
// - request answered by burst acknowledge
// - processor holds address through burst
// - controller generates three following addresses
// - high bits from bus, low from counter
// - counter and memory on inverted clock
// - parallel load pulsed at burst start
// - counter loads start, then increments
// - processor cache blocks are four words
// - 16K by 32 organisation
// - eight 4-bit lanes share address
// - burst ends after fourth word
// - all inputs captured on rising edge
// - edge output: previous cycle read data
module bfc_mem_ctrl #(
    parameter int ADDR_W = `BFC_ADDR_W,
    parameter int LANES  = `BFC_LANES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    bfc_link_if.mem  link,
    // status
    output logic     busy
);
    localparam int LANE_W = `BFC_LANE_W;
    localparam int DEPTH  = 1 << ADDR_W;

    bfc_pkg::bfc_state_t state_reg;
    logic [1:0]          lead_reg;
    logic [1:0]          beats_reg;
    logic                burst_take;
    logic                lead_done;
    logic                counter_parallel_load;
    logic [1:0]          cnt_reg;
    logic [1:0]          cnt_next;
    logic [1:0]          low_addr;
    logic                rd_en_reg;
    logic                wr_reg;
    logic                lane_we;
    logic [ADDR_W-1:0]   mem_addr;
    logic                counter_clock_input;

    // memory and counter share the falling system edge, so addresses
    // settle half a cycle after the processor drives them
    assign counter_clock_input = ~clk;

    // a read burst is taken only from idle; a write never starts one
    assign burst_take = (state_reg == bfc_pkg::BFC_IDLE) &&
                        link.burst_request && !link.write_enable;
    // the lead-in ends at the edge that raises word valid
    assign lead_done  = (state_reg == bfc_pkg::BFC_LEAD) &&
                        (lead_reg == 2'h0);

    // load on the first cycle of a burst, count afterwards
    assign counter_parallel_load = (state_reg == bfc_pkg::BFC_IDLE) &&
                                   link.burst_request;
    assign cnt_next = counter_parallel_load ? link.addr[1:0]
                                            : cnt_reg + 2'h1;

    always_ff @(posedge counter_clock_input or posedge rst) begin
        if (rst) begin
            cnt_reg <= `BFC_CNT_RST;
        end else if (counter_parallel_load || lead_done ||
                     state_reg == bfc_pkg::BFC_BURST) begin
            cnt_reg <= cnt_next;
        end
    end

    // single writes and the burst load address the word directly; the
    // counter steers the low bits at every other edge, idle included
    assign low_addr = (counter_parallel_load || link.write_enable) ?
                      link.addr[1:0] : cnt_reg;
    // high bits straight from the bus, which the processor holds stable
    assign mem_addr = {link.addr[ADDR_W-1:2], low_addr};

    // burst sequencing: idle, lead-in, then one beat per clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= bfc_pkg::BFC_IDLE;
        end else begin
            unique case (state_reg)
                bfc_pkg::BFC_IDLE: begin
                    if (burst_take) begin
                        state_reg <= bfc_pkg::BFC_LEAD;
                    end
                end
                bfc_pkg::BFC_LEAD: begin
                    if (lead_reg == 2'h0) begin
                        state_reg <= bfc_pkg::BFC_BURST;
                    end
                end
                bfc_pkg::BFC_BURST: begin
                    if (beats_reg == 2'h0) begin
                        state_reg <= bfc_pkg::BFC_IDLE;
                    end
                end
            endcase
        end
    end

    // request edge, lead-in and the valid register take one clock
    // each, so the lead-in count is the first-word latency less three
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lead_reg <= 2'h0;
        end else if (burst_take) begin
            lead_reg <= 2'(`BFC_FIRST_LAT - 3);
        end else if (state_reg == bfc_pkg::BFC_LEAD &&
                     lead_reg != 2'h0) begin
            lead_reg <= lead_reg - 2'h1;
        end
    end

    // beats left after the current one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            beats_reg <= 2'h0;
        end else if (lead_done) begin
            beats_reg <= 2'(`BFC_WORDS - 1);
        end else if (state_reg == bfc_pkg::BFC_BURST &&
                     beats_reg != 2'h0) begin
            beats_reg <= beats_reg - 2'h1;
        end
    end

    // acknowledge is one clock, on the edge that takes the burst
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.burst_acknowledge <= 1'b0;
        end else begin
            link.burst_acknowledge <= burst_take;
        end
    end

    // word valid rises as the lead-in ends and stands for four beats
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.word_valid <= 1'b0;
        end else begin
            link.word_valid <= lead_done ||
                               (state_reg == bfc_pkg::BFC_BURST &&
                                beats_reg != 2'h0);
        end
    end

    // busy is registered; its request term raises it in the clock after the one in which a request waits to be taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= state_reg != bfc_pkg::BFC_IDLE ||
                    link.burst_request;
        end
    end

    // input capture on the memory clock; writes are self timed
    always_ff @(posedge counter_clock_input or posedge rst) begin
        if (rst) begin
            rd_en_reg <= 1'b0;
            wr_reg    <= 1'b0;
        end else begin
            rd_en_reg <= 1'b1;
            wr_reg    <= link.write_enable &&
                         state_reg == bfc_pkg::BFC_IDLE;
        end
    end

    // a write that arrives mid-burst is dropped here
    assign lane_we = link.write_enable &&
                     state_reg == bfc_pkg::BFC_IDLE;

    // eight 4-bit lanes on shared address and control
    // the array is not reset; words are undefined until written
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] cells [DEPTH];
            logic [LANE_W-1:0] q_reg;
            logic [LANE_W-1:0] out_reg;
            always_ff @(posedge counter_clock_input) begin
                if (lane_we) begin
                    cells[mem_addr] <= link.wdata[g*LANE_W +: LANE_W];
                end
                q_reg <= cells[mem_addr];
            end
            // edge output stage: shows the read taken one edge earlier
            always_ff @(posedge counter_clock_input or posedge rst) begin
                if (rst) begin
                    out_reg <= '0;
                end else if (rd_en_reg) begin
                    out_reg <= q_reg;
                end
            end
            assign link.rdata[g*LANE_W +: LANE_W] = out_reg;
        end
    endgenerate

    logic unused_ok;
    assign unused_ok = wr_reg;
endmodule
`default_nettype wire

// ---- design/bfc_cpu_end.sv ----
// processor end: issues burst fills and collects four words
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.svh"
module bfc_cpu_end #(
    parameter int ADDR_W = `BFC_ADDR_W,
    parameter int DATA_W = `BFC_DATA_W
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // user side
    input wire logic              fill_start,
    input wire logic [ADDR_W-1:0] fill_addr,
    input wire logic              wr_start,
    input wire logic [DATA_W-1:0] wr_data,
    output logic                  fill_busy,
    output logic                  word_strobe,
    output logic [1:0]            word_index,
    output logic [DATA_W-1:0]     word_data,
    output logic                  fill_done,
    // link
    bfc_link_if.cpu               link
);
    logic [1:0] got_reg;
    logic       wr_reg;
    logic       ack_seen_reg;

    assign link.write_enable = wr_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.burst_request <= 1'b0;
            link.addr          <= '0;
            link.wdata         <= '0;
            wr_reg             <= 1'b0;
            fill_busy          <= 1'b0;
            ack_seen_reg       <= 1'b0;
        end else begin
            wr_reg <= 1'b0;
            if (!fill_busy && fill_start) begin
                link.burst_request <= 1'b1;
                link.addr          <= fill_addr;
                fill_busy          <= 1'b1;
                ack_seen_reg       <= 1'b0;
            end else if (!fill_busy && wr_start) begin
                wr_reg     <= 1'b1;
                link.addr  <= fill_addr;
                link.wdata <= wr_data;
            end else if (fill_busy) begin
                if (link.burst_acknowledge) begin
                    link.burst_request <= 1'b0;
                    ack_seen_reg       <= 1'b1;
                end
                if (link.word_valid && got_reg == 2'h3) begin
                    fill_busy <= 1'b0;
                end
            end
        end
    end

    // words counted in arrival order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            got_reg     <= 2'h0;
            word_strobe <= 1'b0;
            word_index  <= 2'h0;
            word_data   <= '0;
            fill_done   <= 1'b0;
        end else begin
            word_strobe <= fill_busy && link.word_valid;
            fill_done   <= fill_busy && link.word_valid && got_reg == 2'h3;
            if (fill_busy && link.word_valid) begin
                word_index <= got_reg + link.addr[1:0];
                word_data  <= link.rdata;
                got_reg    <= got_reg + 2'h1;
            end else if (!fill_busy) begin
                got_reg <= 2'h0;
            end
        end
    end

    logic unused_ok;
    assign unused_ok = ack_seen_reg;
endmodule
`default_nettype wire

// ---- bench/bfc_link_checker.sv ----
// protocol assertions on the burst fill link
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.svh"
module bfc_link_checker (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   rst,
    // link
    input wire logic                   burst_request,
    input wire logic                   burst_acknowledge,
    input wire logic                   word_valid,
    input wire logic                   write_enable,
    input wire logic [`BFC_ADDR_W-1:0] addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_req_start;
        $rose(burst_request) && !write_enable;
    endsequence
    sequence s_four_beats;
        word_valid [*4] ##1 !word_valid;
    endsequence
    req_ack_a: assert property (s_req_start |=> burst_acknowledge)
        else $error("request not acknowledged next cycle");
    req_hold_a: assert property (s_req_start |-> burst_request [*2])
        else $error("request dropped before acknowledge");
    ack_pulse_a: assert property (burst_acknowledge |=> !burst_acknowledge)
        else $error("acknowledge longer than one cycle");
    ack_cause_a: assert property (burst_acknowledge |-> $past(burst_request))
        else $error("acknowledge without request");
    ack_beats_a: assert property (burst_acknowledge |=> s_four_beats)
        else $error("not four consecutive beats after acknowledge");
    first_beat_a: assert property (s_req_start |-> ##2 word_valid)
        else $error("first word not three cycles after request");
    beat_cause_a: assert property ($rose(word_valid) |-> $past(burst_acknowledge))
        else $error("beats start without acknowledge");
    addr_hold_a: assert property ((burst_acknowledge || word_valid) |-> $stable(addr))
        else $error("address moved during burst");
    no_wr_burst_a: assert property (word_valid |-> !write_enable)
        else $error("write issued during burst");
    we_pulse_a: assert property (write_enable |=> !write_enable)
        else $error("write enable longer than one cycle");
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench: cpu end facing memory end
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.svh"
module testbench;
    logic        clk, rst, fill_start, wr_start, fill_busy, word_strobe;
    logic        fill_done, busy;
    logic [13:0] fill_addr;
    logic [31:0] wr_data, word_data;
    logic [1:0]  word_index;
    logic [31:0] model [0:16383];
    int          mismatches, num_checks;
    bfc_link_if link ();
    bfc_mem_ctrl i_bfc_mem_ctrl (.clk(clk), .rst(rst), .link(link), .busy(busy));
    bfc_cpu_end i_bfc_cpu_end (.clk(clk), .rst(rst), .fill_start(fill_start),
        .fill_addr(fill_addr), .wr_start(wr_start), .wr_data(wr_data),
        .fill_busy(fill_busy), .word_strobe(word_strobe),
        .word_index(word_index), .word_data(word_data),
        .fill_done(fill_done), .link(link));
    bfc_link_checker i_bfc_link_checker (.clk(clk), .rst(rst),
        .burst_request(link.burst_request),
        .burst_acknowledge(link.burst_acknowledge),
        .word_valid(link.word_valid), .write_enable(link.write_enable),
        .addr(link.addr));
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // single write; spacing keeps clear of the write path
    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        fill_addr = a;
        wr_data = d;
        wr_start = 1'b1;
        model[a] = d;
        @(negedge clk) wr_start = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // one burst fill; called at a falling edge, returns after fourth word
    task automatic fill(input logic [13:0] a, input logic poke);
        int          cyc, n;
        logic [1:0]  idx;
        logic [13:0] wa;
        fill_addr = a;
        fill_start = 1'b1;
        @(negedge clk) fill_start = 1'b0;
        cyc = 0;
        n = 0;
        while (n < 4 && cyc < 20) begin
            @(negedge clk) cyc++;
            wr_start = (poke && cyc == 2);
            wr_data = 32'hdead_beef;
            if (word_strobe === 1'b1) begin
                idx = 2'(a[1:0] + n);
                wa = {a[13:2], idx};
                check(cyc === `BFC_FIRST_LAT + n,
                      "word off the 3-1-1-1 beat");
                check(busy === 1'b1, "controller idle during burst");
                check(fill_busy === (n != 3), "fill busy misplaced");
                check(word_index === idx, "word order wrong");
                check(word_data === model[wa], "word data wrong");
                check(fill_done === (n == 3), "done flag misplaced");
                n++;
            end
        end
        wr_start = 1'b0;
        check(n == 4, "burst did not deliver four words");
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        fill_start = 1'b0;
        wr_start = 1'b0;
        fill_addr = 14'h0000;
        wr_data = 32'h0000_0000;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 4; k++) begin
            wr(14'h0124 + 14'(k), {18'h25a5c, 14'h0124 + 14'(k)});
            wr(14'h3ff0 + 14'(k), ~{18'h25a5c, 14'h3ff0 + 14'(k)});
        end
        // back-to-back fills; mid-block starts exercise the wrap
        fill(14'h0126, 1'b0);
        fill(14'h0127, 1'b1);
        fill(14'h3ff0, 1'b0);
        fill(14'h0125, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
